// ===== dv/tcp_hart_model.sv
// Hart pipeline model issuing register accesses and traps
`timescale 1ns/1ps
`default_nettype none
`include "tcp_params.svh"
module tcp_hart_model (
  input wire logic clock,
  input wire tcp_pkg::tcp_rsp_t rsp,
  output var tcp_pkg::tcp_req_t req,
  output var tcp_pkg::tcp_trap_t trap
);
  import tcp_pkg::*;
  initial begin
    req = '0;
    trap = '0;
  end
  // One access, answer taken in the cycle after the taking edge
  task automatic access(input logic we, input logic [11:0] addr, input logic [31:0] wdata,
                        input tcp_priv_t priv, output tcp_rsp_t got);
    @(posedge clock);
    req <= '{valid: 1'b1, we: we, addr: addr, wdata: wdata, priv: priv};
    @(posedge clock);
    req.valid <= 1'b0;
    req.addr <= ~addr;
    req.wdata <= ~wdata;
    #1;
    got = rsp;
  endtask
  // One trap report, released lines show the inverse
  task automatic report(input logic irq, input logic [3:0] code, input logic [31:0] pc, input logic [31:0] addr);
    @(posedge clock);
    trap <= '{valid: 1'b1, irq: irq, code: code, pc: pc, addr: addr};
    @(posedge clock);
    trap <= '{valid: 1'b0, irq: ~irq, code: ~code, pc: ~pc, addr: ~addr};
    #1;
  endtask
endmodule // tcp_hart_model
`default_nettype wire

// ===== dv/trap_csr_and_perf_counters_tb.sv
// Self-checking bench for the trap and counter register block
`timescale 1ns/1ps
`default_nettype none
`include "tcp_params.svh"
module trap_csr_and_perf_counters_tb;
  import tcp_pkg::*;
  typedef struct packed {
    logic we;
    logic [11:0] addr;
    logic [31:0] wdata;
    tcp_priv_t priv;
    logic ill;
    logic [31:0] data;
  } tcp_row_t;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic retire = 1'b0;
  logic [`TCP_NSRC-1:0] evt = '0;
  logic [63:0] mtime = 64'h1122_3344_5566_7788;
  tcp_req_t req;
  tcp_trap_t trap;
  tcp_rsp_t rsp;
  tcp_rsp_t got;
  logic [31:0] epc_out;
  logic [31:0] cause_out;
  logic [31:0] bad_exp;
  logic [31:0] first;
  int errors = 0;
  int num_checks = 0;
  int cycles = 0;
  tcp_row_t rows [$] = '{
    '{1'b1, `TCP_A_SCRATCH, 32'hA5A5_0F0F, TCP_M, 1'b0, 32'h0},
    '{1'b0, `TCP_A_SCRATCH, 32'h0, TCP_M, 1'b0, 32'hA5A5_0F0F},
    '{1'b0, `TCP_A_SCRATCH, 32'h0, TCP_U, 1'b1, 32'h0},
    '{1'b1, `TCP_A_EPC, 32'h1234_5677, TCP_M, 1'b0, 32'h0},
    '{1'b0, `TCP_A_EPC, 32'h0, TCP_M, 1'b0, 32'h1234_5676},
    '{1'b1, `TCP_A_CAUSE, 32'h8000_0003, TCP_M, 1'b0, 32'h0},
    '{1'b1, `TCP_A_CAUSE, 32'h0000_000C, TCP_M, 1'b0, 32'h8000_0003},
    '{1'b0, `TCP_A_CAUSE, 32'h0, TCP_M, 1'b0, 32'h8000_0003},
    '{1'b1, 12'h323, 32'h0000_0009, TCP_M, 1'b0, 32'h0},
    '{1'b0, 12'h323, 32'h0, TCP_M, 1'b0, 32'h0},
    '{1'b0, 12'hB01, 32'h0, TCP_M, 1'b1, 32'h0},
    '{1'b1, 12'hC00, 32'h0000_0001, TCP_M, 1'b1, 32'h0},
    '{1'b0, 12'hB1F, 32'h0, TCP_M, 1'b0, 32'h0},
    '{1'b1, `TCP_A_CEN_U, 32'hFFFF_FFFF, TCP_M, 1'b0, 32'h0},
    '{1'b0, `TCP_A_CEN_U, 32'h0, TCP_M, 1'b0, 32'h0000_007F},
    '{1'b0, 12'hC01, 32'h0, TCP_U, 1'b0, 32'h5566_7788},
    '{1'b0, 12'hC81, 32'h0, TCP_U, 1'b0, 32'h1122_3344},
    '{1'b1, `TCP_A_CEN_U, 32'h0000_007B, TCP_M, 1'b0, 32'h0000_007F},
    '{1'b0, 12'hC02, 32'h0, TCP_U, 1'b1, 32'h0},
    '{1'b0, 12'hC00, 32'h0, TCP_S, 1'b1, 32'h0},
    '{1'b1, `TCP_A_CEN_H, 32'h0000_0002, TCP_M, 1'b0, 32'h0},
    '{1'b0, 12'hC01, 32'h0, TCP_H, 1'b0, 32'h5566_7788},
    '{1'b0, 12'hC1F, 32'h0, TCP_U, 1'b1, 32'h0},
    '{1'b0, 12'hC1F, 32'h0, TCP_M, 1'b0, 32'h0}
  };
  tcp_hart_model hart_u (.clock(clock), .rsp(rsp), .req(req), .trap(trap));
  tcp_trap_csr dut_u (.clock(clock), .resetn(resetn), .req(req), .retire(retire), .evt(evt), .mtime(mtime),
    .trap(trap), .rsp(rsp), .epc_out(epc_out), .cause_out(cause_out));
  always #12.5 clock = ~clock;
  task automatic check_word(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("Error at %0t: word %h expected %h", $time, g, e);
    end
  endtask
  task automatic check_bit(input logic g, input logic e);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("Error at %0t: flag %b expected %b", $time, g, e);
    end
  endtask
  task automatic rd(input logic [11:0] a, input tcp_priv_t p);
    hart_u.access(1'b0, a, 32'h0, p, got);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    hart_u.access(1'b1, a, d, TCP_M, got);
  endtask
  task automatic complete_run();
    $display("Checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      $display("Error at %0t: timeout", $time);
      complete_run();
    end
  end
  initial begin
    repeat (4) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
    #1;
    check_word(epc_out, 32'h0);
    check_word(cause_out, 32'h0);
    check_bit(rsp.valid, 1'b0);
    foreach (rows[i]) begin
      hart_u.access(rows[i].we, rows[i].addr, rows[i].wdata, rows[i].priv, got);
      check_bit(got.valid, 1'b1);
      check_bit(got.illegal, rows[i].ill);
      check_word(got.data, rows[i].data);
    end
    rd(12'hB00, TCP_M);
    first = got.data;
    rd(12'hB00, TCP_M);
    check_word(got.data, first + 32'h2);
    wr(12'hB80, 32'h0000_0007);
    rd(12'hB80, TCP_M);
    check_word(got.data, 32'h0000_0007);
    wr(12'hB82, 32'h0000_0005);
    wr(12'hB02, 32'hFFFF_FFFF);
    @(posedge clock);
    retire <= 1'b1;
    @(posedge clock);
    retire <= 1'b0;
    rd(12'hB82, TCP_M);
    check_word(got.data, 32'h0000_0006);
    rd(12'hC02, TCP_M);
    check_word(got.data, 32'h0);
    wr(12'h323, 32'h0000_0001);
    wr(12'h325, 32'h0000_0008);
    wr(12'hB03, 32'h0);
    wr(12'hB04, 32'h0);
    wr(12'hB05, 32'h0);
    @(posedge clock);
    evt <= 8'hFF;
    repeat (3) @(posedge clock);
    evt <= 8'h00;
    rd(12'hB03, TCP_M);
    check_word(got.data, 32'h0000_0003);
    rd(12'hB04, TCP_M);
    check_word(got.data, 32'h0);
    rd(12'hB05, TCP_M);
    check_word(got.data, 32'h0000_0003);
    bad_exp = 32'h0;
    for (int i = 0; i < 24; i++) begin
      hart_u.report(i >= 12, 4'(i % 12), 32'h1000_0001 + 32'(i * 4), 32'h2000_0000 + 32'(i));
      if (i < 8 && i != 2) bad_exp = 32'h2000_0000 + 32'(i);
      check_word(epc_out, 32'h1000_0000 + 32'(i * 4));
      check_word(cause_out, {i >= 12, 27'h0, 4'(i % 12)});
      rd(`TCP_A_BAD, TCP_M);
      check_word(got.data, bad_exp);
    end
    @(posedge clock);
    resetn <= 1'b0;
    @(posedge clock);
    resetn <= 1'b1;
    #1;
    check_word(epc_out, 32'h0);
    check_word(cause_out, 32'h0);
    rd(`TCP_A_SCRATCH, TCP_M);
    check_word(got.data, 32'h0);
    complete_run();
  end
endmodule // trap_csr_and_perf_counters_tb
`default_nettype wire

// ===== logic/tcp_counter.sv
// One 64-bit counter with separately writable halves
`timescale 1ns/1ps
`default_nettype none
`include "tcp_params.svh"
module tcp_counter (
  input wire logic clock,
  input wire logic resetn,
  input wire logic inc,
  input wire logic wr_lo,
  input wire logic wr_hi,
  input wire logic [31:0] wdata,
  output logic [63:0] count
);
  import tcp_pkg::*;
  tcp_cnt_t s_r;
  tcp_cnt_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    if (inc) begin
      s_nxt.count = s_r.count + 64'h0000_0000_0000_0001; // [RULE_03]
    end
    if (wr_lo) begin
      s_nxt.count[31:0] = wdata;
    end
    if (wr_hi) begin
      s_nxt.count[63:32] = wdata;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s_r.count <= `TCP_RST_COUNT;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign count = s_r.count;
endmodule // tcp_counter
`default_nettype wire

// ===== logic/tcp_gate.sv
// Privilege and counter-enable check for one register access
`timescale 1ns/1ps
`default_nettype none
`include "tcp_params.svh"
module tcp_gate (
  input wire tcp_pkg::tcp_req_t req,
  input wire logic [31:0] cen_h,
  input wire logic [31:0] cen_s,
  input wire logic [31:0] cen_u,
  output logic ok
);
  import tcp_pkg::*;
  logic [6:0] page;
  logic [4:0] idx;
  logic gate;
  logic known;
  logic user_cnt;

  assign page = req.addr[11:5];
  assign idx = req.addr[4:0];
  assign user_cnt = page == `TCP_PG_ULO || page == `TCP_PG_UHI;

  always_comb begin
    case (req.priv)
      TCP_M: gate = 1'b1;
      TCP_H: gate = cen_h[idx]; // [RULE_10] [RULE_23]
      TCP_S: gate = cen_s[idx]; // [RULE_10]
      default: gate = cen_u[idx]; // [RULE_10]
    endcase
  end

  always_comb begin
    case (req.addr)
      `TCP_A_CEN_H, `TCP_A_CEN_S, `TCP_A_CEN_U: known = 1'b1;
      `TCP_A_SCRATCH, `TCP_A_EPC, `TCP_A_CAUSE, `TCP_A_BAD: known = 1'b1;
      default: begin
        if (page == `TCP_PG_MLO || page == `TCP_PG_MHI) begin
          known = idx != `TCP_IDX_TIME;
        end else begin
          known = page == `TCP_PG_SEL && idx >= `TCP_IDX_HPM0;
        end
      end
    endcase
  end

  // User views are read-only; machine registers need machine mode
  assign ok = user_cnt ? (!req.we && gate) : (req.priv == TCP_M && known); // [RULE_12]
endmodule // tcp_gate
`default_nettype wire

// ===== logic/tcp_params.svh
// Constants for the trap, scratch and performance counter registers
`ifndef TCP_PARAMS_SVH
`define TCP_PARAMS_SVH
`define TCP_NEVT 4
`define TCP_NSRC 8
`define TCP_SELW 4
`define TCP_SEL_MAX 32'h0000_0008
`define TCP_EPC_MASK 32'hFFFF_FFFE
`define TCP_CEN_MASK 32'h0000_007F
`define TCP_CAUSE_MAX 4'hB
`define TCP_PG_ULO 7'h60
`define TCP_PG_UHI 7'h64
`define TCP_PG_MLO 7'h58
`define TCP_PG_MHI 7'h5C
`define TCP_PG_SEL 7'h19
`define TCP_IDX_CYCLE 5'h00
`define TCP_IDX_TIME 5'h01
`define TCP_IDX_INSTRET 5'h02
`define TCP_IDX_HPM0 5'h03
`define TCP_A_CEN_H 12'h310
`define TCP_A_CEN_S 12'h311
`define TCP_A_CEN_U 12'h312
`define TCP_A_SCRATCH 12'h340
`define TCP_A_EPC 12'h341
`define TCP_A_CAUSE 12'h342
`define TCP_A_BAD 12'h343
`define TCP_IRQ_SW 4'h0
`define TCP_IRQ_TIMER 4'h4
`define TCP_IRQ_EXT 4'h8
`define TCP_EX_FETCH_MIS 4'h0
`define TCP_EX_FETCH_FLT 4'h1
`define TCP_EX_ILLEGAL 4'h2
`define TCP_EX_BREAK 4'h3
`define TCP_EX_LOAD_MIS 4'h4
`define TCP_EX_LOAD_FLT 4'h5
`define TCP_EX_STORE_MIS 4'h6
`define TCP_EX_STORE_FLT 4'h7
`define TCP_EX_ECALL_U 4'h8
`define TCP_EX_ECALL_M 4'hB
`define TCP_RST_WORD 32'h0000_0000
`define TCP_RST_COUNT 64'h0000_0000_0000_0000
`endif

// ===== logic/tcp_pkg.sv
// Types shared by the trap and counter register block
`default_nettype none
`include "tcp_params.svh"
package tcp_pkg;
  typedef enum logic [1:0] {TCP_U, TCP_S, TCP_H, TCP_M} tcp_priv_t;
  typedef struct packed {
    logic valid;
    logic we;
    logic [11:0] addr;
    logic [31:0] wdata;
    tcp_priv_t priv;
  } tcp_req_t;
  typedef struct packed {
    logic valid;
    logic irq;
    logic [3:0] code;
    logic [31:0] pc;
    logic [31:0] addr;
  } tcp_trap_t;
  typedef struct packed {
    logic valid;
    logic illegal;
    logic [31:0] data;
  } tcp_rsp_t;
  typedef struct packed {
    logic [63:0] count;
  } tcp_cnt_t;
  typedef struct packed {
    logic [31:0] scratch;
    logic [31:0] epc;
    logic [31:0] bad;
    logic cirq;
    logic [3:0] ccode;
    logic [31:0] cen_h;
    logic [31:0] cen_s;
    logic [31:0] cen_u;
    logic [`TCP_NEVT-1:0][`TCP_SELW-1:0] sel;
    tcp_rsp_t rsp;
  } tcp_state_t;
endpackage
`default_nettype wire

// ===== logic/tcp_trap_csr.sv
// Machine trap registers, scratch, counter enables and performance counters
// How it works
// [RULE_01] Cycle counter advances every clock
// [RULE_02] Retired counter advances per retired instruction
// [RULE_03] Cycle and retired counters are 64 bits
// [RULE_04] Event counters 3-31 with own selectors
// [RULE_05] Selector zero means no event
// [RULE_06] Unbuilt event counters and selectors read zero
// [RULE_07] Low and high half views on 32-bit
// [RULE_08] Wide harts sign-extend bit 63
// [RULE_09] Fewer counter bits allowed if wrap unreachable
// [RULE_10] Gate bit clear makes lower-mode read illegal
// [RULE_11] One enable register per lower mode
// [RULE_12] User counter views mirror machine counters read-only
// [RULE_13] Time view mirrors external real-time counter
// [RULE_14] Scratch holds software value, no side effect
// [RULE_15] Exception PC low bit always zero
// [RULE_16] Exception PC never misaligned for fetch
// [RULE_17] Trap writes faulting instruction address
// [RULE_18] Cause sign bit flags interrupt, legal codes
// [RULE_19] Interrupt codes software, timer, external groups
// [RULE_20] Exception codes zero to eleven defined
// [RULE_21] Address faults and breakpoints write bad address
// [RULE_22] Fetch fault bad address is faulting portion
// [RULE_23] Enable bits: cycle 0, time 1, retired 2
`timescale 1ns/1ps
`default_nettype none
`include "tcp_params.svh"
module tcp_trap_csr (
  input wire logic clock,
  input wire logic resetn,
  input wire tcp_pkg::tcp_req_t req,
  input wire logic retire,
  input wire logic [`TCP_NSRC-1:0] evt,
  input wire logic [63:0] mtime,
  input wire tcp_pkg::tcp_trap_t trap,
  output tcp_pkg::tcp_rsp_t rsp,
  output logic [31:0] epc_out,
  output logic [31:0] cause_out
);
  import tcp_pkg::*;

  function automatic logic evt_hit(input logic [`TCP_SELW-1:0] sel, input logic [`TCP_NSRC-1:0] ev);
    evt_hit = 1'b0;
    for (int i = 0; i < `TCP_NSRC; i++) begin
      if (sel == `TCP_SELW'(i + 1) && ev[i]) begin
        evt_hit = 1'b1; // [RULE_05]
      end
    end
  endfunction

  function automatic logic writes_bad(input logic [3:0] code);
    case (code)
      `TCP_EX_FETCH_MIS, `TCP_EX_FETCH_FLT, `TCP_EX_BREAK: writes_bad = 1'b1;
      `TCP_EX_LOAD_MIS, `TCP_EX_LOAD_FLT: writes_bad = 1'b1;
      `TCP_EX_STORE_MIS, `TCP_EX_STORE_FLT: writes_bad = 1'b1;
      default: writes_bad = 1'b0;
    endcase
  endfunction

  tcp_state_t s_r;
  tcp_state_t s_nxt;
  logic ok;
  logic wr;
  logic mlo;
  logic mhi;
  logic [6:0] page;
  logic [4:0] idx;
  logic [63:0] cyc;
  logic [63:0] ins;
  logic [`TCP_NEVT-1:0][63:0] hpm;
  logic [31:0][63:0] cview;
  logic [31:0] rdata;

  assign page = req.addr[11:5];
  assign idx = req.addr[4:0];
  assign wr = req.valid && req.we && ok;
  assign mlo = wr && page == `TCP_PG_MLO;
  assign mhi = wr && page == `TCP_PG_MHI;

  tcp_gate u_gate (
    .req(req),
    .cen_h(s_r.cen_h),
    .cen_s(s_r.cen_s),
    .cen_u(s_r.cen_u),
    .ok(ok)
  );

  tcp_counter u_cycle (
    .clock(clock),
    .resetn(resetn),
    .inc(1'b1), // [RULE_01]
    .wr_lo(mlo && idx == `TCP_IDX_CYCLE),
    .wr_hi(mhi && idx == `TCP_IDX_CYCLE),
    .wdata(req.wdata),
    .count(cyc)
  );

  tcp_counter u_instret (
    .clock(clock),
    .resetn(resetn),
    .inc(retire), // [RULE_02]
    .wr_lo(mlo && idx == `TCP_IDX_INSTRET),
    .wr_hi(mhi && idx == `TCP_IDX_INSTRET),
    .wdata(req.wdata),
    .count(ins)
  );

  for (genvar g = 0; g < `TCP_NEVT; g++) begin : g_hpm
    tcp_counter u_event (
      .clock(clock),
      .resetn(resetn),
      .inc(evt_hit(s_r.sel[g], evt)), // [RULE_04]
      .wr_lo(mlo && idx == 5'(g + 3)),
      .wr_hi(mhi && idx == 5'(g + 3)),
      .wdata(req.wdata),
      .count(hpm[g])
    );
  end

  // Counter views by index; unbuilt event counters stay zero
  always_comb begin
    cview = '0; // [RULE_06]
    cview[`TCP_IDX_CYCLE] = cyc; // [RULE_12]
    cview[`TCP_IDX_TIME] = mtime; // [RULE_13]
    cview[`TCP_IDX_INSTRET] = ins;
    for (int i = 0; i < `TCP_NEVT; i++) begin
      cview[i + 3] = hpm[i];
    end
  end

  // Full 64-bit counters behind a 32-bit view need no extension
  always_comb begin
    rdata = `TCP_RST_WORD;
    case (req.addr)
      `TCP_A_CEN_H: rdata = s_r.cen_h;
      `TCP_A_CEN_S: rdata = s_r.cen_s;
      `TCP_A_CEN_U: rdata = s_r.cen_u;
      `TCP_A_SCRATCH: rdata = s_r.scratch;
      `TCP_A_EPC: rdata = s_r.epc;
      `TCP_A_CAUSE: rdata = {s_r.cirq, 27'h0000000, s_r.ccode}; // [RULE_18]
      `TCP_A_BAD: rdata = s_r.bad;
      default: begin
        if (page == `TCP_PG_ULO || page == `TCP_PG_MLO) begin
          rdata = cview[idx][31:0]; // [RULE_07] [RULE_08] [RULE_09]
        end else if (page == `TCP_PG_UHI || page == `TCP_PG_MHI) begin
          rdata = cview[idx][63:32]; // [RULE_07]
        end else begin
          for (int i = 0; i < `TCP_NEVT; i++) begin
            if (idx == 5'(i + 3)) begin
              rdata = {28'h0000000, s_r.sel[i]};
            end
          end
        end
      end
    endcase
  end

  always_comb begin
    s_nxt = s_r;
    s_nxt.rsp = '0;
    if (req.valid) begin
      s_nxt.rsp.valid = 1'b1;
      s_nxt.rsp.illegal = !ok; // [RULE_10]
      s_nxt.rsp.data = ok ? rdata : `TCP_RST_WORD;
    end
    if (wr) begin
      case (req.addr)
        `TCP_A_CEN_H: s_nxt.cen_h = req.wdata & `TCP_CEN_MASK; // [RULE_11]
        `TCP_A_CEN_S: s_nxt.cen_s = req.wdata & `TCP_CEN_MASK; // [RULE_11]
        `TCP_A_CEN_U: s_nxt.cen_u = req.wdata & `TCP_CEN_MASK; // [RULE_11]
        `TCP_A_SCRATCH: s_nxt.scratch = req.wdata; // [RULE_14]
        `TCP_A_EPC: s_nxt.epc = req.wdata & `TCP_EPC_MASK; // [RULE_15] [RULE_16]
        `TCP_A_CAUSE: begin
          if (req.wdata[3:0] <= `TCP_CAUSE_MAX) begin
            s_nxt.cirq = req.wdata[31]; // [RULE_19] [RULE_20]
            s_nxt.ccode = req.wdata[3:0];
          end
        end
        `TCP_A_BAD: s_nxt.bad = req.wdata;
        default: begin
          for (int i = 0; i < `TCP_NEVT; i++) begin
            if (page == `TCP_PG_SEL && idx == 5'(i + 3)) begin
              s_nxt.sel[i] = (req.wdata <= `TCP_SEL_MAX) ? req.wdata[3:0] : 4'h0; // [RULE_04]
            end
          end
        end
      endcase
    end
    // A trap overrides a software write to EPC and cause in the same cycle, and to bad only for address faults and breakpoints
    if (trap.valid) begin
      s_nxt.epc = trap.pc & `TCP_EPC_MASK; // [RULE_17] [RULE_16]
      s_nxt.cirq = trap.irq; // [RULE_18]
      s_nxt.ccode = trap.code; // [RULE_19] [RULE_20]
      if (!trap.irq && writes_bad(trap.code)) begin
        s_nxt.bad = trap.addr; // [RULE_21] [RULE_22]
      end
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign rsp = s_r.rsp;
  assign epc_out = s_r.epc;
  assign cause_out = {s_r.cirq, 27'h0000000, s_r.ccode};

  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  cycle_count_a: assert property (resetn && !mlo && !mhi |=> cyc == $past(cyc) + 64'h1) // [RULE_01]
    else $error("cycle counter did not advance");
  retire_count_a: assert property (retire && !mlo && !mhi |=> ins == $past(ins) + 64'h1) // [RULE_02]
    else $error("retired counter did not advance");
  sel_zero_a: assert property (s_r.sel[1] == 4'h0 && !mlo && !mhi |=> hpm[1] == $past(hpm[1])) // [RULE_05]
    else $error("event counter moved with selector zero");
  unbuilt_zero_a: assert property (req.valid && ok && req.addr == 12'hC1F |=> rsp.data == 32'h0) // [RULE_06]
    else $error("unbuilt counter read not zero");
  user_gate_a: assert property (req.valid && req.priv == TCP_U && page == `TCP_PG_ULO && !s_r.cen_u[idx] // [RULE_10]
    |=> rsp.valid && rsp.illegal)
    else $error("gated user counter read not trapped");
  high_view_a: assert property (req.valid && ok && page == `TCP_PG_UHI && idx == `TCP_IDX_TIME // [RULE_07]
    |=> rsp.data == $past(mtime[63:32]))
    else $error("high half view wrong");
  epc_align_a: assert property (s_r.epc[0] == 1'b0) // [RULE_15]
    else $error("exception PC misaligned");
  trap_epc_a: assert property (trap.valid |=> epc_out == ($past(trap.pc) & `TCP_EPC_MASK)) // [RULE_17]
    else $error("trap did not record PC");
  cause_flag_a: assert property (trap.valid // [RULE_18]
    |=> cause_out[31] == $past(trap.irq) && cause_out[3:0] == $past(trap.code))
    else $error("cause not recorded");
  bad_keep_a: assert property (trap.valid && !trap.irq && trap.code == `TCP_EX_ILLEGAL && !wr // [RULE_21]
    |=> $stable(s_r.bad))
    else $error("bad address changed on other exception");
  scratch_a: assert property (wr && req.addr == `TCP_A_SCRATCH && !trap.valid // [RULE_14]
    |=> s_r.scratch == $past(req.wdata))
    else $error("scratch lost written value");

  illegal_data_a: assert property (rsp.valid && rsp.illegal |-> rsp.data == 32'h0) // [RULE_10]
    else $error("refused access returned data");
  answer_pulse_a: assert property (req.valid |=> rsp.valid) // [RULE_10]
    else $error("access got no answer");
  idle_answer_a: assert property (!req.valid |=> !rsp.valid) // [RULE_10]
    else $error("answer without access");
  gate_open_a: assert property (req.valid && !req.we && req.priv == TCP_U // [RULE_10]
    && page == `TCP_PG_ULO && s_r.cen_u[idx] |=> !rsp.illegal)
    else $error("enabled user counter read refused");
  super_gate_a: assert property (req.valid && !req.we && req.priv == TCP_S // [RULE_10]
    && page == `TCP_PG_ULO && !s_r.cen_s[idx] |=> rsp.illegal)
    else $error("gated supervisor counter read not trapped");
  hyper_gate_a: assert property (req.valid && !req.we && req.priv == TCP_H // [RULE_10]
    && page == `TCP_PG_ULO && s_r.cen_h[idx] |=> !rsp.illegal)
    else $error("enabled hypervisor counter read refused");
  machine_pass_a: assert property (req.valid && !req.we && req.priv == TCP_M // [RULE_10]
    && page == `TCP_PG_ULO |=> !rsp.illegal)
    else $error("machine counter view read refused");
  user_ro_a: assert property (req.valid && req.we // [RULE_12]
    && (page == `TCP_PG_ULO || page == `TCP_PG_UHI) |=> rsp.illegal)
    else $error("user counter view accepted a write");
  mirror_ret_a: assert property (req.valid && ok && page == `TCP_PG_ULO // [RULE_12]
    && idx == `TCP_IDX_INSTRET |=> rsp.data == $past(ins[31:0]))
    else $error("retired view does not mirror counter");
  time_low_a: assert property (req.valid && ok && page == `TCP_PG_ULO // [RULE_13]
    && idx == `TCP_IDX_TIME |=> rsp.data == $past(mtime[31:0]))
    else $error("time view does not mirror real-time counter");
  cen_mask_a: assert property (s_r.cen_h[31:7] == 25'h0 // [RULE_11] [RULE_23]
    && s_r.cen_s[31:7] == 25'h0 && s_r.cen_u[31:7] == 25'h0)
    else $error("unbuilt counter enable bit set");
  cause_legal_a: assert property (s_r.ccode <= `TCP_CAUSE_MAX) // [RULE_18]
    else $error("cause holds unsupported code");
  cause_write_a: assert property (wr && req.addr == `TCP_A_CAUSE // [RULE_18] [RULE_20]
    && req.wdata[3:0] > `TCP_CAUSE_MAX && !trap.valid |=> $stable(cause_out))
    else $error("unsupported cause code stored");
  sel_legal_a: assert property (s_r.sel[0] <= 4'h8 && s_r.sel[1] <= 4'h8 // [RULE_04]
    && s_r.sel[2] <= 4'h8 && s_r.sel[3] <= 4'h8)
    else $error("selector holds illegal event");
  event_count_a: assert property (s_r.sel[0] != 4'h0 && evt[3'(s_r.sel[0] - 4'h1)] // [RULE_04]
    && !mlo && !mhi |=> hpm[0] == $past(hpm[0]) + 64'h1)
    else $error("event counter missed its event");
  bad_write_a: assert property (trap.valid && !trap.irq && trap.code != `TCP_EX_ILLEGAL // [RULE_21] [RULE_22]
    && trap.code <= `TCP_EX_STORE_FLT |=> s_r.bad == $past(trap.addr))
    else $error("faulting address not recorded");
  irq_bad_a: assert property (trap.valid && trap.irq && !wr |=> $stable(s_r.bad)) // [RULE_21]
    else $error("interrupt changed bad address");
  ecall_bad_a: assert property (trap.valid && !trap.irq // [RULE_20] [RULE_21]
    && trap.code >= `TCP_EX_ECALL_U && !wr |=> $stable(s_r.bad))
    else $error("environment call changed bad address");
  epc_write_a: assert property (wr && req.addr == `TCP_A_EPC && !trap.valid // [RULE_15]
    |=> s_r.epc == ($past(req.wdata) & `TCP_EPC_MASK))
    else $error("exception PC write not aligned");
  cycle_hi_a: assert property (mhi && idx == `TCP_IDX_CYCLE |=> cyc[63:32] == $past(req.wdata)) // [RULE_07]
    else $error("cycle high half write lost");
  ret_lo_a: assert property (mlo && idx == `TCP_IDX_INSTRET |=> ins[31:0] == $past(req.wdata)) // [RULE_07]
    else $error("retired low half write lost");

  cause_keep_c: cover property (wr && req.addr == `TCP_A_CAUSE && req.wdata[3:0] > `TCP_CAUSE_MAX);
  trap_irq_c: cover property (trap.valid && trap.irq && trap.code == `TCP_IRQ_TIMER);
  gate_trap_c: cover property (rsp.valid && rsp.illegal);
  event_inc_c: cover property (s_r.sel[0] != 4'h0 ##1 hpm[0] != $past(hpm[0]));
  fetch_bad_c: cover property (trap.valid && !trap.irq && trap.code == `TCP_EX_FETCH_FLT);
endmodule // tcp_trap_csr
`default_nettype wire
